//--- hdl/pet_consts.svh
// Constants for the periodic endpoint transfer block
// Assumes inclusion by bare name from the top module and the bench
`ifndef PET_CONSTS_SVH
`define PET_CONSTS_SVH
`define PET_BUS_INTERVAL_NS 125000
`define PET_CLK_PERIOD_NS 10
`define PET_MAX_PKT_BYTES 11'h400
`define PET_INT_MAX_BURST 5'h03
`define PET_ISO_MAX_BURST 5'h10
`define PET_MAX_BURSTS_PER_SI 2'h3
`define PET_INTERVAL_MIN 5'h01
`define PET_INTERVAL_MAX 5'h10
`define PET_SEQ_LAST 5'h1f
`define PET_SEQ_ZERO 5'h00
`define PET_OFS_CTRL 32'h0000_0000
`define PET_OFS_CFG 32'h0000_0004
`define PET_OFS_STAT 32'h0000_0008
`define PET_OFS_CNT 32'h0000_000c
`define PET_RESP_OKAY 2'h0
`define PET_RESP_SLVERR 2'h2
`endif

//--- hdl/pet_pkg.sv
// Types shared by the periodic endpoint transfer block
// Assumes pet_consts.svh is on the include path
package pet_pkg;
    typedef enum logic [1:0] {PET_TT_INT, PET_TT_ISO} pet_ttype_t;
    typedef enum logic [2:0] {PET_R_DATA, PET_R_ZLP, PET_R_FLOW, PET_R_STALL, PET_R_PINGRSP, PET_R_NONE} pet_resp_t;
    typedef struct packed {
        logic [10:0] max_pkt;
        logic [4:0] burst;
        logic [4:0] interval;
        logic dir_in;
        pet_ttype_t ttype;
    } pet_cfg_t;
    typedef struct packed {
        logic valid;
        logic ping;
        logic is_in;
        logic [10:0] len;
    } pet_req_t;
    typedef struct packed {
        pet_resp_t kind;
        logic [4:0] seq;
        logic [10:0] len;
    } pet_ans_t;
endpackage

//--- hdl/pet_top.sv
// Periodic endpoint transfer engine: interrupt and isochronous endpoint
// sequencing, service interval timing, flow control, halt, ping, notify.
// Assumes the link layer presents decoded requests on clk and that
// configuration control transfers are signalled by cfg_done.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pet_consts.svh"
module pet_top #(
    parameter int BUS_INTERVAL_CYCLES = `PET_BUS_INTERVAL_NS / `PET_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Endpoint configuration
    input wire pet_pkg::pet_cfg_t cfg_in,
    input wire logic cfg_done,
    // Link side requests
    input wire pet_pkg::pet_req_t req,
    output pet_pkg::pet_ans_t ans,
    output logic ans_valid,
    // Function side
    input wire logic tx_pending,
    input wire logic [10:0] tx_len,
    input wire logic rx_space,
    input wire logic func_stall,
    input wire logic retry_exhausted,
    input wire logic notify_req,
    output logic notify_send,
    output logic cfg_ok,
    // AXI4-Lite slave
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    import pet_pkg::*;

    initial begin
        if (BUS_INTERVAL_CYCLES < 2) begin
            $error("pet_top: bus interval too short");
        end
    end

    pet_cfg_t cfg_r;
    logic cfg_ok_r;
    logic [31:0] bi_cnt_r;
    logic [14:0] si_cnt_r;
    logic si_tick;
    logic [4:0] seq_r;
    logic [4:0] pkt_cnt_r;
    logic [1:0] burst_cnt_r;
    logic halt_r;
    logic sw_halt_clr;
    logic sw_notify;
    logic [15:0] ans_cnt_r;
    logic [14:0] si_len;
    logic last_in_burst;
    logic quota_left;

    function automatic logic cfg_legal(input pet_cfg_t c);
        logic ok;
        ok = (c.interval >= `PET_INTERVAL_MIN) && (c.interval <= `PET_INTERVAL_MAX);
        ok = ok && (c.max_pkt <= `PET_MAX_PKT_BYTES) && (c.burst != 5'h00);
        if (c.ttype == PET_TT_ISO) begin
            ok = ok && (c.burst <= `PET_ISO_MAX_BURST);
        end else begin
            ok = ok && (c.burst <= `PET_INT_MAX_BURST) && (c.max_pkt != 11'h000);
        end
        if (c.burst != 5'h01) begin
            ok = ok && (c.max_pkt == `PET_MAX_PKT_BYTES);
        end
        return ok;
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_r <= '0;
            cfg_ok_r <= 1'b0;
        end else if (clk_en && cfg_done) begin
            cfg_r <= cfg_in;
            cfg_ok_r <= cfg_legal(cfg_in);
        end
    end
    assign cfg_ok = cfg_ok_r;

    assign si_len = 15'(15'h0001 << (cfg_r.interval - 5'h01));

    // bus interval timer is the finest granule
    always_ff @(posedge clk) begin
        if (sys_rst || (clk_en && cfg_done)) begin
            bi_cnt_r <= '0;
        end else if (clk_en) begin
            if (bi_cnt_r == 32'(BUS_INTERVAL_CYCLES - 1)) begin
                bi_cnt_r <= '0;
            end else begin
                bi_cnt_r <= bi_cnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || (clk_en && cfg_done)) begin
            si_cnt_r <= '0;
        end else if (clk_en && bi_cnt_r == 32'(BUS_INTERVAL_CYCLES - 1)) begin
            if (si_cnt_r >= si_len - 15'h0001) begin
                si_cnt_r <= '0;
            end else begin
                si_cnt_r <= si_cnt_r + 15'h0001;
            end
        end
    end
    assign si_tick = clk_en && (bi_cnt_r == 32'(BUS_INTERVAL_CYCLES - 1)) && (si_cnt_r >= si_len - 15'h0001);

    assign last_in_burst = (pkt_cnt_r + 5'h01 >= cfg_r.burst);
    assign quota_left = (burst_cnt_r < `PET_MAX_BURSTS_PER_SI);

    logic data_req;
    logic accept_data;
    pet_resp_t kind_nxt;
    logic [10:0] len_nxt;
    assign data_req = req.valid && !req.ping;

    // Response selection
    always_comb begin
        kind_nxt = PET_R_NONE;
        len_nxt = 11'h000;
        accept_data = 1'b0;
        if (req.valid && req.ping) begin
            kind_nxt = PET_R_PINGRSP;
        end else if (data_req && cfg_ok_r) begin
            if (cfg_r.ttype == PET_TT_ISO) begin
                // wrong direction ignored, never flow controlled
                if (req.is_in == cfg_r.dir_in && quota_left) begin
                    accept_data = 1'b1;
                    if (!cfg_r.dir_in) begin
                        kind_nxt = PET_R_NONE;
                    end else if (tx_pending) begin
                        // true length, clipped to max packet
                        kind_nxt = PET_R_DATA;
                        len_nxt = (tx_len > cfg_r.max_pkt) ? cfg_r.max_pkt : tx_len;
                    end else begin
                        kind_nxt = PET_R_ZLP;
                    end
                end
            end else if (halt_r) begin
                kind_nxt = PET_R_STALL;
            end else if (func_stall) begin
                kind_nxt = PET_R_STALL;
            end else if (!quota_left) begin
                // quota used, defer to next interval
                kind_nxt = PET_R_FLOW;
            end else if (cfg_r.dir_in) begin
                if (tx_pending) begin
                    accept_data = 1'b1;
                    kind_nxt = PET_R_DATA;
                    // zero length is a valid completion
                    len_nxt = (tx_len > cfg_r.max_pkt) ? cfg_r.max_pkt : tx_len;
                end else begin
                    kind_nxt = PET_R_FLOW;
                end
            end else begin
                if (rx_space) begin
                    accept_data = 1'b1;
                    kind_nxt = PET_R_DATA;
                    len_nxt = req.len;
                end else begin
                    kind_nxt = PET_R_FLOW;
                end
            end
        end
    end

    // attempts taken at any cycle of the interval
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ans <= '{kind: PET_R_NONE, seq: `PET_SEQ_ZERO, len: 11'h000};
            ans_valid <= 1'b0;
        end else if (clk_en) begin
            ans_valid <= (kind_nxt != PET_R_NONE);
            ans <= '{kind: kind_nxt, seq: seq_r, len: len_nxt};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || (clk_en && cfg_done)) begin
            seq_r <= `PET_SEQ_ZERO;
        end else if (clk_en && si_tick && cfg_r.ttype == PET_TT_ISO) begin
            seq_r <= `PET_SEQ_ZERO;
        end else if (clk_en && accept_data) begin
            seq_r <= (seq_r == `PET_SEQ_LAST) ? `PET_SEQ_ZERO : seq_r + 5'h01;
        end
    end

    // burst position and burst count per interval
    always_ff @(posedge clk) begin
        if (sys_rst || (clk_en && (cfg_done || si_tick))) begin
            pkt_cnt_r <= '0;
            burst_cnt_r <= '0;
        end else if (clk_en && accept_data) begin
            // a short packet closes the burst
            if (last_in_burst || len_nxt < cfg_r.max_pkt) begin
                pkt_cnt_r <= '0;
                burst_cnt_r <= burst_cnt_r + 2'h1;
            end else begin
                pkt_cnt_r <= pkt_cnt_r + 5'h01;
            end
        end
    end

    // halt set wins over a software clear
    always_ff @(posedge clk) begin
        if (sys_rst || (clk_en && cfg_done)) begin
            halt_r <= 1'b0;
        end else if (clk_en) begin
            if (cfg_r.ttype == PET_TT_INT && (retry_exhausted || kind_nxt == PET_R_STALL)) begin
                halt_r <= 1'b1;
            end else if (sw_halt_clr) begin
                halt_r <= 1'b0;
            end
        end
    end

    // notification at any time, never blocked by pipe state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            notify_send <= 1'b0;
        end else if (clk_en) begin
            notify_send <= notify_req || sw_notify;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || (clk_en && cfg_done)) begin
            ans_cnt_r <= '0;
        end else if (clk_en && accept_data) begin
            ans_cnt_r <= ans_cnt_r + 16'h0001;
        end
    end

    // AXI4-Lite: address and data may arrive in either order
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic wr_fire;
    assign s_awready = !aw_held_r && !s_bvalid;
    assign s_wready = !w_held_r && !s_bvalid;
    assign wr_fire = aw_held_r && w_held_r && !s_bvalid;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            s_bvalid <= 1'b0;
            s_bresp <= `PET_RESP_OKAY;
        end else if (clk_en) begin
            if (s_awvalid && s_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_wstrb[0] ? s_wdata : 32'h0000_0000;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (awaddr_r == `PET_OFS_CTRL) ? `PET_RESP_OKAY : `PET_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end
    assign sw_halt_clr = clk_en && wr_fire && (awaddr_r == `PET_OFS_CTRL) && wdata_r[0];
    assign sw_notify = clk_en && wr_fire && (awaddr_r == `PET_OFS_CTRL) && wdata_r[1];

    assign s_arready = !s_rvalid;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= `PET_RESP_OKAY;
        end else if (clk_en) begin
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= `PET_RESP_OKAY;
                unique case (s_araddr)
                    `PET_OFS_CTRL: s_rdata <= '0;
                    `PET_OFS_CFG: s_rdata <= 32'({cfg_r.ttype, cfg_r.dir_in, cfg_r.interval, cfg_r.burst, cfg_r.max_pkt});
                    `PET_OFS_STAT: s_rdata <= 32'({burst_cnt_r, pkt_cnt_r, seq_r, cfg_ok_r, halt_r});
                    `PET_OFS_CNT: s_rdata <= 32'(ans_cnt_r);
                    default: begin
                        s_rdata <= '0;
                        s_rresp <= `PET_RESP_SLVERR;
                    end
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Assertions
    AST_PING_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && req.valid && req.ping) |=> (ans_valid && ans.kind == PET_R_PINGRSP))
        else $error("ping not answered");
    AST_ISO_NO_FLOW: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_r.ttype == PET_TT_ISO && ans_valid) |-> (ans.kind != PET_R_FLOW && ans.kind != PET_R_STALL))
        else $error("iso flow control");
    AST_ISO_ZLP: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && data_req && cfg_ok_r && cfg_r.ttype == PET_TT_ISO && cfg_r.dir_in && req.is_in && !tx_pending
         && quota_left && !cfg_done) |=> (ans.kind == PET_R_ZLP && ans.len == 11'h000))
        else $error("iso no zlp");
    AST_MAXPKT: assert property (@(posedge clk) disable iff (sys_rst)
        (ans_valid && ans.kind == PET_R_DATA && cfg_r.dir_in) |-> (ans.len <= cfg_r.max_pkt))
        else $error("packet too big");
    AST_INT_FLOW: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && data_req && cfg_ok_r && cfg_r.ttype == PET_TT_INT && cfg_r.dir_in && !tx_pending && !halt_r
         && !func_stall && !cfg_done) |=> (ans.kind == PET_R_FLOW))
        else $error("no flow control");
    AST_SEQ_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && accept_data && seq_r == `PET_SEQ_LAST && !si_tick && !cfg_done) |=> (seq_r == `PET_SEQ_ZERO))
        else $error("seq wrap");
    AST_ISO_SEQ_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        (si_tick && cfg_r.ttype == PET_TT_ISO) |=> (seq_r == `PET_SEQ_ZERO))
        else $error("iso seq not zeroed");
    AST_CFG_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && cfg_done) |=> (seq_r == `PET_SEQ_ZERO && pkt_cnt_r == 5'h00 && !halt_r))
        else $error("cfg reset");
    AST_HALT: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && !cfg_done && cfg_r.ttype == PET_TT_INT && retry_exhausted) |=> halt_r)
        else $error("halt missing");
    AST_BURSTS: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && data_req && cfg_ok_r && burst_cnt_r == `PET_MAX_BURSTS_PER_SI && !si_tick && !cfg_done)
        |=> (ans.kind inside {PET_R_FLOW, PET_R_STALL, PET_R_NONE}))
        else $error("burst quota");
    AST_NOTIFY: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && notify_req) |=> notify_send)
        else $error("notify lost");
    COV_PING: cover property (@(posedge clk) ans_valid && ans.kind == PET_R_PINGRSP);
    COV_WRAP: cover property (@(posedge clk) accept_data && seq_r == `PET_SEQ_LAST);
    COV_HALT: cover property (@(posedge clk) $rose(halt_r));
    COV_ZLP: cover property (@(posedge clk) ans_valid && ans.kind == PET_R_ZLP);
endmodule

//--- sim/pet_host_model.sv
// Host controller model driving the periodic endpoint link side
// Assumes the bench raises go for one cycle per request and reads seen later
`timescale 1ns/1ps
module pet_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bench commands
    input wire logic go,
    input wire logic ping,
    input wire logic is_in,
    input wire logic [10:0] len,
    input wire logic [10:0] max_pkt,
    output logic seen,
    output pet_pkg::pet_ans_t seen_ans,
    // Device link side
    output pet_pkg::pet_req_t req,
    input wire pet_pkg::pet_ans_t ans,
    input wire logic ans_valid
);
    import pet_pkg::*;
    // one attempt per command, never retried
    // pacing and retries come from the bench
    always @(posedge clk) begin
        if (sys_rst) begin
            req <= '0;
            seen <= 1'b0;
            seen_ans <= '0;
        end else begin
            req.valid <= go;
            // Idle fields toggle so a stale value is never mistaken for a request
            req.ping <= go ? ping : ~req.ping;
            req.is_in <= go ? is_in : ~req.is_in;
            req.len <= !go ? ~req.len : ((len > max_pkt) ? max_pkt : len);
            seen <= ans_valid;
            if (ans_valid) begin
                seen_ans <= ans;
            end
        end
    end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the periodic endpoint transfer engine
// Assumes a 20-cycle bus interval and the host model on the link side
`timescale 1ns/1ps
`include "pet_consts.svh"
`define CHK(got_v, exp_v, what) \
    begin \
        samples_checked++; \
        if ((got_v) !== (exp_v)) begin \
            miscompares++; \
            $display("BAD %0t %s", $time, what); \
        end \
    end
module tb_top;
    import pet_pkg::*;
    logic clk, sys_rst, clk_en, cfg_done, ans_valid, tx_pending, rx_space, func_stall, retry_exhausted;
    logic notify_req, notify_send, cfg_ok, go, ping, is_in, seen, got;
    logic [10:0] tx_len, len;
    pet_cfg_t cfg_in;
    pet_req_t req;
    pet_ans_t ans, seen_ans, gans;
    logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rd;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, rr;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    int miscompares = 0;
    int samples_checked = 0;
    int notify_cnt = 0;

    pet_top #(.BUS_INTERVAL_CYCLES(20)) pet_top_i (.clk, .sys_rst, .clk_en, .cfg_in, .cfg_done, .req, .ans,
        .ans_valid, .tx_pending, .tx_len, .rx_space, .func_stall, .retry_exhausted, .notify_req, .notify_send,
        .cfg_ok, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    pet_host_model pet_host_model_i (.clk, .sys_rst, .go, .ping, .is_in, .len, .max_pkt(cfg_in.max_pkt),
        .seen, .seen_ans, .req, .ans, .ans_valid);

    task automatic finish_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Ready is read mid-cycle, where it has settled, and acted on at the next rising edge
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, ta, tw, tb;
        pa = 1'b1;
        pw = 1'b1;
        r = 2'h1;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = pa && s_awready;
            tw = pw && s_wready;
            tb = s_bvalid;
            if (tb) r = s_bresp;
            @(posedge clk);
            if (ta) begin
                pa = 1'b0;
                s_awvalid <= 1'b0;
            end
            if (tw) begin
                pw = 1'b0;
                s_wvalid <= 1'b0;
            end
        end while (!tb);
        s_bready <= 1'b0;
    endtask

    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        r = 2'h1;
        d = 32'hffff_ffff;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = s_arready;
            tr = s_rvalid;
            if (tr) d = s_rdata;
            if (tr) r = s_rresp;
            @(posedge clk);
            if (ta) s_arvalid <= 1'b0;
        end while (!tr);
        s_rready <= 1'b0;
    endtask

    task automatic cfg(input pet_ttype_t t, input logic d, input logic [4:0] b, input logic [4:0] iv,
                       input logic [10:0] m);
        cfg_in <= '{max_pkt: m, burst: b, interval: iv, dir_in: d, ttype: t};
        cfg_done <= 1'b1;
        @(posedge clk);
        cfg_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // One request; the answer lands in got and gans
    task automatic xfer(input logic p, input logic i, input logic [10:0] l);
        go <= 1'b1;
        ping <= p;
        is_in <= i;
        len <= l;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        got = seen;
        gans = seen_ans;
        // A missing answer must not pass on the previous one
        if (!got) begin
            gans = '{kind: PET_R_NONE, seq: 5'h1f, len: 11'h7ff};
        end
        @(posedge clk);
    endtask

    task automatic t_regs;
        axr(`PET_OFS_STAT, rd, rr);
        `CHK(rd, 32'h0000_0000, "stat reset")
        `CHK(rr, `PET_RESP_OKAY, "stat resp")
        axr(`PET_OFS_CNT, rd, rr);
        `CHK(rd, 32'h0000_0000, "cnt reset")
        axr(32'h0000_0010, rd, rr);
        `CHK(rr, `PET_RESP_SLVERR, "unmapped resp")
        `CHK(rd, 32'h0000_0000, "unmapped data")
        axw(`PET_OFS_CFG, 32'h0000_ffff, rr);
        `CHK(rr, `PET_RESP_SLVERR, "ro write resp")
        axw(`PET_OFS_CTRL, 32'h0000_0000, rr);
        `CHK(rr, `PET_RESP_OKAY, "ctrl write resp")
    endtask

    task automatic t_legal;
        pet_ttype_t t [6] = '{PET_TT_ISO, PET_TT_ISO, PET_TT_ISO, PET_TT_INT, PET_TT_INT, PET_TT_INT};
        logic [4:0] b [6] = '{5'h02, 5'h11, 5'h01, 5'h04, 5'h02, 5'h03};
        logic [10:0] m [6] = '{11'h200, 11'h400, 11'h000, 11'h400, 11'h200, 11'h400};
        logic ok [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int k = 0; k < 6; k++) begin
            cfg(t[k], 1'b1, b[k], 5'h01, m[k]);
            `CHK(cfg_ok, ok[k], "config legality")
        end
    endtask

    task automatic t_int;
        cfg(PET_TT_INT, 1'b1, 5'h01, 5'h04, 11'h400);
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_FLOW, "idle IN")
        tx_pending <= 1'b1;
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind inside {PET_R_DATA, PET_R_ZLP}, 1'b1, "zero length kind")
        `CHK(gans.len, 11'h000, "zero length len")
        `CHK(gans.seq, 5'h00, "first seq")
        tx_len <= 11'h400;
        for (int k = 1; k < 3; k++) begin
            xfer(1'b0, 1'b1, 11'h000);
            `CHK(gans.seq, 5'(k), "int seq")
            `CHK(gans.len, 11'h400, "int len")
        end
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_FLOW, "quota")
        xfer(1'b1, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_PINGRSP, "ping")
        repeat (170) @(posedge clk);
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_DATA, "next interval")
        `CHK(gans.seq, 5'h03, "seq carries")
        func_stall <= 1'b1;
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_STALL, "stall")
        func_stall <= 1'b0;
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_STALL, "halt kept")
        axr(`PET_OFS_STAT, rd, rr);
        `CHK(rd[0], 1'b1, "halt flag")
        axw(`PET_OFS_CTRL, 32'h0000_0001, rr);
        repeat (170) @(posedge clk);
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_DATA, "halt cleared")
        retry_exhausted <= 1'b1;
        @(posedge clk);
        retry_exhausted <= 1'b0;
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_STALL, "retry halt")
        cfg(PET_TT_INT, 1'b0, 5'h01, 5'h04, 11'h400);
        rx_space <= 1'b0;
        xfer(1'b0, 1'b0, 11'h010);
        `CHK(gans.kind, PET_R_FLOW, "out full")
        rx_space <= 1'b1;
        xfer(1'b0, 1'b0, 11'h010);
        `CHK(gans.kind, PET_R_DATA, "out accept")
        axr(`PET_OFS_CNT, rd, rr);
        `CHK(rd, 32'h0000_0001, "accept count")
    endtask

    task automatic t_iso;
        tx_pending <= 1'b0;
        cfg(PET_TT_ISO, 1'b1, 5'h10, 5'h05, 11'h400);
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.kind, PET_R_ZLP, "iso no data")
        `CHK(gans.len, 11'h000, "zlp len")
        // Quota still open here, so only the direction check can refuse it
        xfer(1'b0, 1'b0, 11'h010);
        `CHK(got, 1'b0, "wrong direction")
        tx_pending <= 1'b1;
        cfg(PET_TT_ISO, 1'b1, 5'h10, 5'h05, 11'h400);
        for (int k = 0; k < 33; k++) begin
            xfer(1'b0, 1'b1, 11'h000);
            `CHK(gans.seq, 5'(k), "iso seq")
            `CHK(gans.len, 11'h400, "iso len")
        end
        tx_len <= 11'h064;
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.len, 11'h064, "short len")
        repeat (330) @(posedge clk);
        xfer(1'b0, 1'b1, 11'h000);
        `CHK(gans.seq, 5'h00, "seq restart")
    endtask

    task automatic t_notify;
        int n0;
        n0 = notify_cnt;
        axw(`PET_OFS_CTRL, 32'h0000_0002, rr);
        `CHK(notify_cnt, n0 + 1, "sw notify")
        notify_req <= 1'b1;
        @(posedge clk);
        notify_req <= 1'b0;
        @(negedge clk);
        `CHK(notify_send, 1'b1, "notify")
        @(negedge clk);
        `CHK(notify_send, 1'b0, "notify pulse")
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Notification pulses are too short for a task to catch in passing
    always @(negedge clk) begin
        if (notify_send === 1'b1) begin
            notify_cnt++;
        end
    end

    initial begin
        {sys_rst, clk_en} = 2'b11;
        {cfg_done, tx_pending, rx_space, func_stall, retry_exhausted, notify_req, go, ping, is_in} = '0;
        {tx_len, len, cfg_in} = '0;
        {s_awaddr, s_wdata, s_araddr} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        s_wstrb = 4'hf;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        `CHK({ans_valid, s_bvalid, s_rvalid, cfg_ok}, 4'h0, "reset outputs")
        @(posedge clk);
        t_regs;
        t_legal;
        t_int;
        t_iso;
        t_notify;
        finish_test;
    end

    initial begin
        repeat (10000) @(posedge clk);
        miscompares++;
        finish_test;
    end
endmodule
